// ### rtl/canopen_emergency_reporter.sv
`timescale 1ns/1ps
// Watches the warning level and terminal error state and builds one
// emergency telegram per change. Changes are only taken while the sender
// is idle, so a change that occurs during a send is reported afterwards
// against the state then current; one undone by then gives no telegram.
module canopen_emergency_reporter (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic [6:0]                      node_addr,
   input  wire logic                            warn_exceeded,
   input  wire logic                            term_error,
   input  wire logic [7:0]                      term_slot,
   input  wire logic [7:0]                      term_diag,
   input  wire logic                            tx_ready,
   output logic                                 tx_valid,
   output logic [10:0]                          tx_id,
   output emcy_pkg::byte_t [emcy_pkg::NUM_BYTES-1:0] tx_data
);
   import emcy_pkg::*;

   // ----------------------------------------------------------------
   // Local sizes
   // ----------------------------------------------------------------
   // Both error inputs come from outside this clock domain. Two stages
   // keep a metastable first stage away from the change detection.
   localparam int SYNC_STAGES  = 2;
   localparam int ASYNC_INPUTS = 2;
   // Bit offsets of the two error inputs in the synchroniser bank.
   localparam int IDX_WARN     = 0;
   localparam int IDX_TERM     = 1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // One synchroniser chain, first stage in bit 0.
   typedef logic [SYNC_STAGES-1:0] sync_t;
   typedef byte_t [NUM_BYTES-1:0]  frame_t;

   // The reported state is what the network was last told. A telegram
   // goes out whenever the synchronised inputs differ from it.
   // Only one terminal fault is tracked, so a second fault that comes
   // while the first is active is not reported on its own.
   typedef struct packed {
      sync_t [ASYNC_INPUTS-1:0] sync;
      logic                     warn;
      logic                     term;
      byte_t                    slot;
      byte_t                    diag;
   } rep_s;

   // ----------------------------------------------------------------
   // Telegram field builders
   // ----------------------------------------------------------------
   // True while any error is still reported.
   function automatic logic any_active_f(
      input logic warn,
      input logic term
   );
      return warn || term;
   endfunction : any_active_f

   // Every active error leaves its mark, not only the one that changed.
   function automatic byte_t err_reg_f(
      input logic warn,
      input logic term
   );
      byte_t r;

      r = 8'h00;
      if (any_active_f(warn, term)) begin
         r[ERRREG_GENERIC] = 1'b1;
      end
      if (warn) begin
         r[ERRREG_COMM]  = 1'b1;
         r[ERRREG_MANUF] = 1'b1;
      end
      if (term) begin
         r[ERRREG_MANUF] = 1'b1;
      end
      return r;
   endfunction : err_reg_f

   // Bit field 0 only carries the warning flag; all other bits stay zero.
   function automatic byte_t field0_f(
      input logic warn
   );
      byte_t f;

      f                  = 8'h00;
      f[FIELD0_WARN_BIT] = warn;
      return f;
   endfunction : field0_f

   // Bit field 1 only carries the terminal error flag.
   function automatic byte_t field1_f(
      input logic term
   );
      byte_t f;

      f                  = 8'h00;
      f[FIELD1_TERM_BIT] = term;
      return f;
   endfunction : field1_f

   // A cleared error reports the reset code whichever error it was.
   function automatic logic [15:0] err_code_f(
      input event_e ev,
      input logic   warn,
      input logic   term
   );
      logic [15:0] c;

      c = CODE_RESET;
      case (ev)
         EV_WARN: begin
            c = warn ? CODE_COMM : CODE_RESET;
         end
         EV_TERM: begin
            c = term ? CODE_HW : CODE_RESET;
         end
         default: begin
            c = CODE_RESET;
         end
      endcase
      return c;
   endfunction : err_code_f

   // The trigger names the event that caused this telegram, not the state.
   function automatic byte_t trigger_f(
      input event_e ev
   );
      byte_t t;

      t = TRIG_WARN;
      case (ev)
         EV_TERM: begin
            t = TRIG_TERM;
         end
         default: begin
            t = TRIG_WARN;
         end
      endcase
      return t;
   endfunction : trigger_f

   // Warning changes win a tie; the terminal change then goes out in the
   // next telegram, so neither is lost.
   function automatic event_e pick_event_f(
      input logic warn_moved,
      input logic term_moved
   );
      event_e e;

      e = EV_NONE;
      if (warn_moved) begin
         e = EV_WARN;
      end else if (term_moved) begin
         e = EV_TERM;
      end
      return e;
   endfunction : pick_event_f

   // Slot and status bytes follow the terminal error, so a warning
   // telegram still carries them while a terminal fault stays active.
   function automatic frame_t pack_frame_f(
      input event_e ev,
      input logic   warn,
      input logic   term,
      input byte_t  slot,
      input byte_t  diag
   );
      frame_t      f;
      logic [15:0] c;

      f    = '0;
      c    = err_code_f(ev, warn, term);
      // Byte 0 goes first on the wire, so the code goes low byte first.
      f[0] = c[7:0];
      f[1] = c[15:8];
      f[2] = err_reg_f(warn, term);
      f[3] = field0_f(warn);
      f[4] = field1_f(term);
      f[5] = trigger_f(ev);
      if (term) begin
         f[6] = slot;
         f[7] = diag;
      end
      // Once nothing remains active the telegram is all zero.
      if (!any_active_f(warn, term)) begin
         f = '0;
      end
      return f;
   endfunction : pack_frame_f

   // ----------------------------------------------------------------
   // State and nets
   // ----------------------------------------------------------------
   rep_s                     s_q;
   rep_s                     s_d;
   sync_t [ASYNC_INPUTS-1:0] sync_d;
   logic [ASYNC_INPUTS-1:0]  async_in;
   logic [ASYNC_INPUTS-1:0]  synced;
   logic                     busy;
   logic                     warn_now;
   logic                     term_now;
   logic                     warn_moved;
   logic                     term_moved;
   event_e                   ev;
   frame_t                   frame;

   // The built telegram travels to the sender register as one bundle.
   emcy_frame_if frm_if ();

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   assign async_in[IDX_WARN] = warn_exceeded;
   assign async_in[IDX_TERM] = term_error;

   // Only the last stage is read; the first may still be settling.
   for (genvar k = 0; k < ASYNC_INPUTS; k++) begin : g_sync
      assign sync_d[k] = {s_q.sync[k][SYNC_STAGES-2:0], async_in[k]};
      assign synced[k] = s_q.sync[k][SYNC_STAGES-1];
   end

   assign warn_now = synced[IDX_WARN];
   assign term_now = synced[IDX_TERM];

   // ----------------------------------------------------------------
   // Change detection
   // ----------------------------------------------------------------
   // Changes are only looked at while nothing is on offer. A change that
   // comes and goes within one busy time therefore leaves no telegram,
   // which is right: the network already holds the state that remains.
   assign busy       = tx_valid;
   assign warn_moved = (warn_now != s_q.warn);
   assign term_moved = (term_now != s_q.term);

   // ----------------------------------------------------------------
   // Reported state and telegram building
   // ----------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.sync = sync_d;
      ev       = EV_NONE;
      if (!busy) begin
         ev = pick_event_f(warn_moved, term_moved);
      end
      case (ev)
         EV_WARN: begin
            s_d.warn = warn_now;
         end
         EV_TERM: begin
            s_d.term = term_now;
            if (term_now) begin
               // Slot and status are kept from the rise, so the telegrams
               // that follow report the fault that was logged.
               s_d.slot = term_slot;
               s_d.diag = term_diag;
            end
         end
         default: begin
            // Nothing changes; the reported state stands.
            s_d.warn = s_q.warn;
         end
      endcase
      frame = pack_frame_f(ev, s_d.warn, s_d.term, s_d.slot, s_d.diag);
   end

   // ----------------------------------------------------------------
   // Hand-over to the sender register
   // ----------------------------------------------------------------
   // The identifier is rebuilt for every telegram, so an address change
   // between telegrams is picked up without a reset.
   assign frm_if.load   = (ev != EV_NONE);
   assign frm_if.can_id = EMCY_ID_BASE + {4'h0, node_addr};
   assign frm_if.data   = frame;

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset leaves every error unreported, so an error present at release
   // gives its telegram once it has passed the synchronisers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Sender register
   // ----------------------------------------------------------------
   emcy_frame_hold u_hold (
      .clk      (clk),
      .rst      (rst),
      .frm      (frm_if.holder),
      .tx_ready (tx_ready),
      .tx_valid (tx_valid),
      .tx_id    (tx_id),
      .tx_data  (tx_data)
   );
endmodule : canopen_emergency_reporter

// ### rtl/emcy_pkg.sv
package emcy_pkg;

   // ----------------------------------------------------------------
   // Telegram constants
   // ----------------------------------------------------------------
   localparam logic [10:0] EMCY_ID_BASE     = 11'h080;
   localparam logic [15:0] CODE_RESET       = 16'h0000;
   localparam logic [15:0] CODE_COMM        = 16'h8100;
   localparam logic [15:0] CODE_HW          = 16'h5000;
   localparam logic [7:0]  TRIG_WARN        = 8'h01;
   localparam logic [7:0]  TRIG_TERM        = 8'h10;
   localparam int          ERRREG_GENERIC   = 0;
   localparam int          ERRREG_COMM      = 4;
   localparam int          ERRREG_MANUF     = 7;
   localparam int          FIELD0_WARN_BIT  = 7;
   localparam int          FIELD1_TERM_BIT  = 0;
   localparam int          DIAG_ERR_BIT     = 7;
   localparam int          NUM_BYTES        = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic [7:0] byte_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } tx_state_e;

   typedef enum logic [1:0] {
      EV_NONE = 2'b00,
      EV_WARN = 2'b01,
      EV_TERM = 2'b10
   } event_e;

endpackage : emcy_pkg

// ### rtl/emcy_frame_if.sv
`timescale 1ns/1ps
// Carries one built telegram from the builder to the sender register.
interface emcy_frame_if;
   import emcy_pkg::*;
   logic                  load;
   logic [10:0]           can_id;
   byte_t [NUM_BYTES-1:0] data;

   modport builder (output load, output can_id, output data);
   modport holder  (input  load, input  can_id, input  data);
endinterface : emcy_frame_if

// ### rtl/emcy_frame_hold.sv
`timescale 1ns/1ps
// Holds the telegram and offers it until the transmitter accepts it.
module emcy_frame_hold (
   input  wire logic                            clk,
   input  wire logic                            rst,
   emcy_frame_if.holder                         frm,
   input  wire logic                            tx_ready,
   output logic                                 tx_valid,
   output logic [10:0]                          tx_id,
   output emcy_pkg::byte_t [emcy_pkg::NUM_BYTES-1:0] tx_data
);
   import emcy_pkg::*;

   typedef struct packed {
      tx_state_e             st;
      logic [10:0]           id;
      byte_t [NUM_BYTES-1:0] data;
   } hold_s;

   hold_s s_q;
   hold_s s_d;

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         ST_IDLE: begin
            if (frm.load) begin
               s_d.st   = ST_SEND;
               s_d.id   = frm.can_id;
               s_d.data = frm.data;
            end
         end
         ST_SEND: begin
            if (tx_ready) begin
               s_d.st = ST_IDLE;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tx_valid = (s_q.st == ST_SEND);
   assign tx_id    = s_q.id;
   assign tx_data  = s_q.data;
endmodule : emcy_frame_hold

// ### test/emcy_sink_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Transmitter stand-in
// ----------------------------------------
// In slow mode it stalls each offer for three cycles to exercise holding.
module emcy_sink_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic tx_valid,
   input  wire logic slow,
   output logic      tx_ready
);
   logic [1:0] wait_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) wait_q <= 2'h0;
      else wait_q <= tx_valid ? wait_q + 2'h1 : 2'h0;
   end
   assign tx_ready = !slow || wait_q == 2'h3;
endmodule : emcy_sink_model

// ### test/canopen_emergency_reporter_monitor.sv
`timescale 1ns/1ps
module canopen_emergency_reporter_monitor (
   input wire logic                                   clk,
   input wire logic                                   rst,
   input wire logic [6:0]                             node_addr,
   input wire logic                                   warn_exceeded,
   input wire logic                                   term_error,
   input wire logic [7:0]                             term_slot,
   input wire logic [7:0]                             term_diag,
   input wire logic                                   tx_ready,
   input wire logic                                   tx_valid,
   input wire logic [10:0]                            tx_id,
   input wire emcy_pkg::byte_t [emcy_pkg::NUM_BYTES-1:0] tx_data
);
   import emcy_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence warn_up; !tx_valid && $rose(warn_exceeded); endsequence
   sequence hw_offer; tx_valid && tx_data[5] == TRIG_TERM && tx_data[4][0]; endsequence
   id_value_a: assert property (tx_valid |-> tx_id == EMCY_ID_BASE + 11'(node_addr)) else $error("bad id");
   hold_offer_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("offer moved");
   one_send_a: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("repeated offer");
   warn_lat_a: assert property (warn_up |-> ##[1:4] tx_valid) else $error("no warning telegram");
   comm_code_a: assert property (tx_valid && tx_data[5] == TRIG_WARN && tx_data[3][7]
      |-> tx_data[1:0] == 16'h8100) else $error("bad comm code");
   hw_code_a: assert property (hw_offer |-> tx_data[1:0] == 16'h5000 && tx_data[4][0]
      && tx_data[6] == term_slot && tx_data[7] == term_diag) else $error("bad hw telegram");
   err_reg_a: assert property (tx_valid && (tx_data[3] != 8'h00 || tx_data[4] != 8'h00)
      |-> tx_data[2] == {1'h1, 2'h0, tx_data[3][7], 3'h0, 1'h1}) else $error("bad error register");
   reset_code_a: assert property (tx_valid && tx_data[5] == TRIG_WARN && !tx_data[3][7]
      |-> tx_data[1:0] == 16'h0000) else $error("bad reset code");
   all_zero_a: assert property (tx_valid && tx_data[3] == 8'h00 && tx_data[4] == 8'h00
      |-> tx_data == '0) else $error("clear telegram not zero");
endmodule : canopen_emergency_reporter_monitor
bind canopen_emergency_reporter canopen_emergency_reporter_monitor mon_inst (.clk(clk), .rst(rst),
   .node_addr(node_addr), .warn_exceeded(warn_exceeded), .term_error(term_error), .term_slot(term_slot),
   .term_diag(term_diag), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_id(tx_id), .tx_data(tx_data));

// ### test/canopen_emergency_reporter_test.sv
`timescale 1ns/1ps
module canopen_emergency_reporter_test;
   import emcy_pkg::*;
   logic                  clk = 0, rst = 1, warn_exceeded = 0, term_error = 0, slow = 0, tx_ready, tx_valid;
   logic [6:0]            node_addr = 7'h05;
   logic [7:0]            term_slot = 8'h00, term_diag = 8'h00;
   logic [10:0]           tx_id;
   byte_t [NUM_BYTES-1:0] tx_data;
   int                    err_total = 0, total_checks = 0;
   always #20 clk = ~clk;
   canopen_emergency_reporter canopen_emergency_reporter_inst (.clk(clk), .rst(rst), .node_addr(node_addr),
      .warn_exceeded(warn_exceeded), .term_error(term_error), .term_slot(term_slot), .term_diag(term_diag),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_id(tx_id), .tx_data(tx_data));
   emcy_sink_model emcy_sink_model_inst (.clk(clk), .rst(rst), .tx_valid(tx_valid), .slow(slow),
      .tx_ready(tx_ready));
   task automatic test_done();
      if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic chk(string n, logic [63:0] s, logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   // Waits for one offer, judges it, then waits for it to be taken.
   task automatic frame(logic [63:0] e);
      int i;
      for (i = 0; i < 12 && tx_valid !== 1'b1; i++) tick(1);
      chk("offer", 64'(i < 12), 64'h1);
      if (i == 12) test_done();
      chk("id", 64'(tx_id), 64'(EMCY_ID_BASE + 11'(node_addr)));
      chk("data", tx_data, e);
      for (i = 0; i < 12 && tx_valid !== 1'b0; i++) tick(1);
      chk("taken", 64'(i < 12), 64'h1);
      if (i == 12) test_done();
   endtask : frame
   task automatic walk_slow();
      slow = 1;
      warn_exceeded = 1;
      frame(64'h0000_0100_8091_8100);
      term_slot = 8'h0A;
      term_diag = 8'h82;
      term_error = 1;
      frame(64'h820A_1001_8091_5000);
      warn_exceeded = 0;
      frame(64'h820A_0101_0081_0000);
      term_error = 0;
      frame(64'h0);
      tick(8);
      chk("quiet", 64'(tx_valid), 64'h0);
   endtask : walk_slow
   task automatic both_fast();
      slow = 0;
      node_addr = 7'h7F;
      warn_exceeded = 1;
      term_error = 1;
      frame(64'h0000_0100_8091_8100);
      frame(64'h820A_1001_8091_5000);
      warn_exceeded = 0;
      term_error = 0;
      frame(64'h820A_0101_0081_0000);
      frame(64'h0);
   endtask : both_fast
   task automatic term_only();
      node_addr = 7'h01;
      term_slot = 8'h03;
      term_diag = 8'h81;
      term_error = 1;
      frame(64'h8103_1001_0081_5000);
      term_error = 0;
      frame(64'h0);
   endtask : term_only
   initial begin
      tick(10);
      rst = 0;
      tick(2);
      walk_slow();
      both_fast();
      term_only();
      test_done();
   end
endmodule : canopen_emergency_reporter_test
